// ==== verilog/lighting_cfg_pkg.sv ====
// Shared constants, register layouts and tables for the lighting configuration block
package lighting_cfg_pkg;

	// ==================================================
	// Register offsets
	localparam logic [7:0] ADDR_PAT_CTRL = 8'h11;
	localparam logic [7:0] ADDR_LIMIT1 = 8'h12;
	localparam logic [7:0] ADDR_LIMIT2 = 8'h13;
	localparam logic [7:0] ADDR_AUDIO_A = 8'h2a;
	localparam logic [7:0] ADDR_AUDIO_B = 8'h2b;
	localparam logic [7:0] ADDR_STEP_BASE = 8'h50;
	localparam logic [7:0] ADDR_STEP_MASK = 8'hf0;
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h60;

	// ==================================================
	// Reset values
	localparam logic [7:0] LIMIT_RESET = 8'h00;
	localparam logic [7:0] AUDIO_A_RESET = 8'h03;
	localparam logic [7:0] AUDIO_B_RESET = 8'h00;
	localparam logic [7:0] PAT_CTRL_RESET = 8'h00;
	localparam logic [7:0] STEP_RESET = 8'h00;

	// ==================================================
	// Register layouts, most significant field first
	typedef struct packed {
		logic [1:0] zero;
		logic [1:0] red;
		logic [1:0] green;
		logic [1:0] blue;
	} limit_reg_t;

	typedef struct packed {
		logic [2:0] gain;
		logic filter_freq;
		logic agc_en;
		logic sync_en;
		logic [1:0] adc_src;
	} audio_a_t;

	typedef struct packed {
		logic [2:0] zero;
		logic avg_en;
		logic [1:0] filter_ctrl;
		logic [1:0] speed;
	} audio_b_t;

	typedef struct packed {
		logic [3:0] zero;
		logic blink_start;
		logic start;
		logic repeat_en;
		logic log_curve;
	} pat_ctrl_t;

	typedef struct packed {
		logic [2:0] red;
		logic [2:0] green;
		logic [1:0] exec_hi;
	} step_a_t;

	typedef struct packed {
		logic [1:0] exec_lo;
		logic [2:0] blue;
		logic [2:0] ramp_code;
	} step_b_t;

	typedef struct packed {
		logic [6:0] red;
		logic [6:0] green;
		logic [6:0] blue;
	} color_t;

	typedef enum logic [3:0] {
		SEQ_IDLE = 4'b0001,
		SEQ_LOAD = 4'b0010,
		SEQ_RAMP = 4'b0100,
		SEQ_HOLD = 4'b1000
	} seq_state_t;

	// ==================================================
	// Timing
	localparam int CLK_PERIOD_NSEC = 5;
	localparam int TICK_NSEC = 100000;
	localparam int TICK_CYCLES = TICK_NSEC / CLK_PERIOD_NSEC;
	localparam int TICKS_PER_MS = 1000000 / TICK_NSEC;
	localparam int TIME_W = 16;
	localparam int STEP_COUNT = 8;
	localparam int ADC_FAST_HZ = 122;
	localparam int ADC_AVG_HZ = 244;
	localparam int ADC_AVG_SAMPLES = 64;
	localparam int ADC_FAST_TICKS = 1000000000 / ADC_FAST_HZ / TICK_NSEC;
	localparam int ADC_AVG_TICKS = 1000000000 / ADC_AVG_HZ / TICK_NSEC;
	localparam int RAMP_PCT_STEPS = 100;

	localparam int CET_MS [16] = '{197, 393, 590, 786, 983, 1180, 1376, 1573,
		1769, 1966, 2163, 2359, 2556, 2753, 2949, 3146};
	localparam int RAMP_MS [8] = '{0, 55, 110, 221, 442, 885, 1770, 3539};
	localparam int LIN_PCT [8] = '{0, 7, 14, 21, 32, 46, 71, 100};
	localparam int LOG_PCT [8] = '{0, 1, 2, 4, 10, 21, 46, 100};

	function automatic logic [TIME_W-1:0] exec_ticks(input logic [3:0] code);
		exec_ticks = TIME_W'(CET_MS[code] * TICKS_PER_MS);
	endfunction

	function automatic logic [TIME_W-1:0] ramp_ticks(input logic [2:0] code);
		ramp_ticks = TIME_W'(RAMP_MS[code] * TICKS_PER_MS);
	endfunction

	// Ticks between one-percent steps of a ramp, never below one
	function automatic logic [TIME_W-1:0] ramp_step_ticks(input logic [2:0] code);
		int t;
		t = RAMP_MS[code] * TICKS_PER_MS / RAMP_PCT_STEPS;
		ramp_step_ticks = (t < 1) ? TIME_W'(1) : TIME_W'(t);
	endfunction

endpackage

// ==== verilog/interval_counter.sv ====
// Down counter in tick units that reports when its interval has run out
`timescale 1ns/1ps
module interval_counter #(
	parameter int W = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic tick,
	input wire logic load,
	input wire logic [W-1:0] load_ticks,
	output logic done
);

	logic [W-1:0] count_reg;
	logic [W-1:0] count_next;

	always_comb
	begin
		count_next = count_reg;
		if (load)
			count_next = load_ticks;
		else if (tick && count_reg != '0)
			count_next = count_reg - W'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			count_reg <= '0;
		else if (ce)
			count_reg <= count_next;
	end

	assign done = (count_reg == '0);

endmodule

// ==== verilog/intensity_map.sv ====
// Maps a three-bit colour code onto percent of full current, linear or logarithmic
`timescale 1ns/1ps
module intensity_map (
	input wire logic [2:0] code,
	input wire logic log_curve,
	output logic [6:0] pct
);

	always_comb
	begin
		if (log_curve)
			pct = 7'(lighting_cfg_pkg::LOG_PCT[code]);
		else
			pct = 7'(lighting_cfg_pkg::LIN_PCT[code]);
	end

endmodule

// ==== verilog/lighting_cfg_regs.sv ====
// Register bank, colour pattern sequencer and converter pacing of the lighting controller
`timescale 1ns/1ps

// How it works
// - Any write to 60H resets whole device
// - Two-bit limit codes: quarter steps of current
// - Second triplet same layout; bits 7-6 zero
// - Gain bits 7-5, 3 dB steps, reset 0
// - Bit 4 picks amplitude or frequency filter
// - Bit 3 enables automatic gain control
// - Bit 2 enables audio colour synchronisation
// - Bits 1-0 choose converter source, reset 11
// - Converter paced 122 Hz, or averaged 64 at 244
// - Response speed bits 1-0, reset fastest
// - Byte A: red, green, execution high bits
// - Byte B: execution low, blue, ramp code
// - Red code maps linear or logarithmic table
// - Green and blue share the red tables
// - Execution time code in 196.6 ms steps
// - Ramp code picks transition from table
// - Start bit runs from command one; clear stops
// - Repeat bit: once or until stopped
// - Curve bit selects linear or logarithmic mapping
module lighting_cfg_regs #(
	parameter int TICK_CYCLES = lighting_cfg_pkg::TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data,
	output logic soft_reset,
	output lighting_cfg_pkg::limit_reg_t limit1,
	output lighting_cfg_pkg::limit_reg_t limit2,
	output lighting_cfg_pkg::audio_a_t audio_a,
	output lighting_cfg_pkg::audio_b_t audio_b,
	output lighting_cfg_pkg::color_t colour,
	output logic seq_active,
	output logic [2:0] seq_step,
	output logic adc_sample,
	output logic adc_update
);

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);
	localparam int TW = lighting_cfg_pkg::TIME_W;

	function automatic logic is_step(input logic [7:0] a);
		is_step = (a & lighting_cfg_pkg::ADDR_STEP_MASK) == lighting_cfg_pkg::ADDR_STEP_BASE;
	endfunction

	// ==================================================
	// Register file
	logic int_rst;
	logic soft_rst_reg, soft_rst_next;
	lighting_cfg_pkg::limit_reg_t limit1_reg, limit1_next, limit2_reg, limit2_next;
	lighting_cfg_pkg::audio_a_t audio_a_reg, audio_a_next;
	lighting_cfg_pkg::audio_b_t audio_b_reg, audio_b_next;
	lighting_cfg_pkg::pat_ctrl_t pat_reg, pat_next;
	lighting_cfg_pkg::step_a_t step_a_reg [lighting_cfg_pkg::STEP_COUNT];
	lighting_cfg_pkg::step_a_t step_a_next [lighting_cfg_pkg::STEP_COUNT];
	lighting_cfg_pkg::step_b_t step_b_reg [lighting_cfg_pkg::STEP_COUNT];
	lighting_cfg_pkg::step_b_t step_b_next [lighting_cfg_pkg::STEP_COUNT];
	logic [7:0] rd_data_reg, rd_data_next;

	// The trigger register resets itself, so the soft reset is exactly one cycle
	assign int_rst = sys_rst | soft_rst_reg;

	always_comb
	begin
		soft_rst_next = wr_en && addr == lighting_cfg_pkg::ADDR_SOFT_RESET;
		limit1_next = limit1_reg;
		limit2_next = limit2_reg;
		audio_a_next = audio_a_reg;
		audio_b_next = audio_b_reg;
		pat_next = pat_reg;
		step_a_next = step_a_reg;
		step_b_next = step_b_reg;
		rd_data_next = rd_data_reg;
		if (wr_en)
		begin
			unique case (addr)
				lighting_cfg_pkg::ADDR_LIMIT1: limit1_next = {2'h0, wr_data[5:0]};
				lighting_cfg_pkg::ADDR_LIMIT2: limit2_next = {2'h0, wr_data[5:0]};
				lighting_cfg_pkg::ADDR_AUDIO_A: audio_a_next = wr_data;
				lighting_cfg_pkg::ADDR_AUDIO_B: audio_b_next = {3'h0, wr_data[4:0]};
				lighting_cfg_pkg::ADDR_PAT_CTRL: pat_next = {4'h0, wr_data[3:0]};
				default:
				begin
					if (is_step(addr) && addr[0])
						step_b_next[addr[3:1]] = wr_data;
					else if (is_step(addr))
						step_a_next[addr[3:1]] = wr_data;
				end
			endcase
		end
		if (rd_en)
		begin
			unique case (addr)
				lighting_cfg_pkg::ADDR_LIMIT1: rd_data_next = limit1_reg;
				lighting_cfg_pkg::ADDR_LIMIT2: rd_data_next = limit2_reg;
				lighting_cfg_pkg::ADDR_AUDIO_A: rd_data_next = audio_a_reg;
				lighting_cfg_pkg::ADDR_AUDIO_B: rd_data_next = audio_b_reg;
				lighting_cfg_pkg::ADDR_PAT_CTRL: rd_data_next = pat_reg;
				default:
				begin
					// Trigger register and unmapped offsets read as zero
					if (is_step(addr) && addr[0])
						rd_data_next = step_b_reg[addr[3:1]];
					else if (is_step(addr))
						rd_data_next = step_a_reg[addr[3:1]];
					else
						rd_data_next = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (int_rst)
		begin
			soft_rst_reg <= 1'b0;
			limit1_reg <= lighting_cfg_pkg::LIMIT_RESET;
			limit2_reg <= lighting_cfg_pkg::LIMIT_RESET;
			audio_a_reg <= lighting_cfg_pkg::AUDIO_A_RESET;
			audio_b_reg <= lighting_cfg_pkg::AUDIO_B_RESET;
			pat_reg <= lighting_cfg_pkg::PAT_CTRL_RESET;
			for (int i = 0; i < lighting_cfg_pkg::STEP_COUNT; i++)
			begin
				step_a_reg[i] <= lighting_cfg_pkg::STEP_RESET;
				step_b_reg[i] <= lighting_cfg_pkg::STEP_RESET;
			end
			rd_data_reg <= 8'h00;
		end
		else if (ce)
		begin
			soft_rst_reg <= soft_rst_next;
			limit1_reg <= limit1_next;
			limit2_reg <= limit2_next;
			audio_a_reg <= audio_a_next;
			audio_b_reg <= audio_b_next;
			pat_reg <= pat_next;
			step_a_reg <= step_a_next;
			step_b_reg <= step_b_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// ==================================================
	// Time base: one tick every 100 us
	logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick;

	assign tick = (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1));

	always_comb
	begin
		tick_cnt_next = tick ? '0 : tick_cnt_reg + TICK_W'(1);
	end

	always_ff @(posedge sys_clk)
	begin
		if (int_rst)
			tick_cnt_reg <= '0;
		else if (ce)
			tick_cnt_reg <= tick_cnt_next;
	end

	// ==================================================
	// Converter pacing
	logic adc_done;
	logic [5:0] avg_cnt_reg, avg_cnt_next;
	logic adc_update_next;

	interval_counter #(.W(TW)) adc_timer (
		.sys_clk(sys_clk),
		.sys_rst(int_rst),
		.ce(ce),
		.tick(tick),
		.load(adc_done),
		.load_ticks(audio_b_reg.avg_en ? TW'(lighting_cfg_pkg::ADC_AVG_TICKS)
			: TW'(lighting_cfg_pkg::ADC_FAST_TICKS)),
		.done(adc_done)
	);

	always_comb
	begin
		avg_cnt_next = avg_cnt_reg;
		adc_update_next = 1'b0;
		if (adc_done)
		begin
			avg_cnt_next = audio_b_reg.avg_en ? avg_cnt_reg + 6'h01 : 6'h00;
			// Averaging publishes only after a full set of samples
			adc_update_next = !audio_b_reg.avg_en
				|| avg_cnt_reg == 6'(lighting_cfg_pkg::ADC_AVG_SAMPLES - 1);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (int_rst)
		begin
			avg_cnt_reg <= 6'h00;
			adc_sample <= 1'b0;
			adc_update <= 1'b0;
		end
		else if (ce)
		begin
			avg_cnt_reg <= avg_cnt_next;
			adc_sample <= adc_done;
			adc_update <= adc_update_next;
		end
	end

	// ==================================================
	// Pattern sequencer
	lighting_cfg_pkg::seq_state_t state_reg, state_next;
	logic [2:0] idx_reg, idx_next;
	logic start_prev_reg;
	lighting_cfg_pkg::color_t cur_reg, cur_next;
	logic [6:0] target [3];
	logic [6:0] cur_arr [3];
	logic [6:0] nxt_arr [3];
	logic [2:0] code_arr [3];
	logic [TW-1:0] step_cnt_reg, step_cnt_next;
	logic ramp_done, exec_done, seq_load;
	lighting_cfg_pkg::step_a_t sa;
	lighting_cfg_pkg::step_b_t sb;

	assign sa = step_a_reg[idx_reg];
	assign sb = step_b_reg[idx_reg];
	assign code_arr[0] = sa.red;
	assign code_arr[1] = sa.green;
	assign code_arr[2] = sb.blue;
	assign cur_arr[0] = cur_reg.red;
	assign cur_arr[1] = cur_reg.green;
	assign cur_arr[2] = cur_reg.blue;
	assign seq_load = (state_reg == lighting_cfg_pkg::SEQ_LOAD);

	generate
		for (genvar c = 0; c < 3; c++)
		begin : g_color
			intensity_map color_map (
				.code(code_arr[c]),
				.log_curve(pat_reg.log_curve),
				.pct(target[c])
			);
		end
	endgenerate

	interval_counter #(.W(TW)) ramp_timer (
		.sys_clk(sys_clk),
		.sys_rst(int_rst),
		.ce(ce),
		.tick(tick),
		.load(seq_load),
		.load_ticks(lighting_cfg_pkg::ramp_ticks(sb.ramp_code)),
		.done(ramp_done)
	);

	// Execution time counts from the start of the command, ramp included
	interval_counter #(.W(TW)) exec_timer (
		.sys_clk(sys_clk),
		.sys_rst(int_rst),
		.ce(ce),
		.tick(tick),
		.load(seq_load),
		.load_ticks(lighting_cfg_pkg::exec_ticks({sa.exec_hi, sb.exec_lo})),
		.done(exec_done)
	);

	always_comb
	begin
		state_next = state_reg;
		idx_next = idx_reg;
		step_cnt_next = step_cnt_reg;
		nxt_arr = cur_arr;
		unique case (state_reg)
			lighting_cfg_pkg::SEQ_IDLE:
			begin
				nxt_arr = '{default: 7'h00};
				if (pat_reg.start && !start_prev_reg)
				begin
					idx_next = 3'h0;
					state_next = lighting_cfg_pkg::SEQ_LOAD;
				end
			end
			lighting_cfg_pkg::SEQ_LOAD:
			begin
				step_cnt_next = lighting_cfg_pkg::ramp_step_ticks(sb.ramp_code);
				state_next = lighting_cfg_pkg::SEQ_RAMP;
			end
			lighting_cfg_pkg::SEQ_RAMP:
			begin
				if (ramp_done)
				begin
					nxt_arr = target;
					state_next = lighting_cfg_pkg::SEQ_HOLD;
				end
				else if (tick)
				begin
					step_cnt_next = step_cnt_reg - TW'(1);
					if (step_cnt_reg == TW'(1))
					begin
						step_cnt_next = lighting_cfg_pkg::ramp_step_ticks(sb.ramp_code);
						for (int c = 0; c < 3; c++)
						begin
							if (cur_arr[c] < target[c])
								nxt_arr[c] = cur_arr[c] + 7'h01;
							else if (cur_arr[c] > target[c])
								nxt_arr[c] = cur_arr[c] - 7'h01;
						end
					end
				end
			end
			lighting_cfg_pkg::SEQ_HOLD:
			begin
				if (exec_done)
				begin
					idx_next = idx_reg + 3'h1;
					if (idx_reg == 3'(lighting_cfg_pkg::STEP_COUNT - 1) && !pat_reg.repeat_en)
						state_next = lighting_cfg_pkg::SEQ_IDLE;
					else
						state_next = lighting_cfg_pkg::SEQ_LOAD;
				end
			end
			default:
				state_next = lighting_cfg_pkg::SEQ_IDLE;
		endcase
		// Clearing the start bit stops the generator from any state
		if (!pat_reg.start)
			state_next = lighting_cfg_pkg::SEQ_IDLE;
		cur_next = {nxt_arr[0], nxt_arr[1], nxt_arr[2]};
	end

	always_ff @(posedge sys_clk)
	begin
		if (int_rst)
		begin
			state_reg <= lighting_cfg_pkg::SEQ_IDLE;
			idx_reg <= 3'h0;
			start_prev_reg <= 1'b0;
			cur_reg <= '0;
			step_cnt_reg <= '0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			idx_reg <= idx_next;
			start_prev_reg <= pat_reg.start;
			cur_reg <= cur_next;
			step_cnt_reg <= step_cnt_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign soft_reset = soft_rst_reg;
	assign limit1 = limit1_reg;
	assign limit2 = limit2_reg;
	assign audio_a = audio_a_reg;
	assign audio_b = audio_b_reg;
	assign colour = cur_reg;
	assign seq_active = (state_reg != lighting_cfg_pkg::SEQ_IDLE);
	assign seq_step = idx_reg;

	// ==================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (int_rst);

	// The soft reset pulse raises int_rst itself, so only the pin reset may gate this check
	a_soft_reset_pulse: assert property (disable iff (sys_rst)
		ce && wr_en && addr == lighting_cfg_pkg::ADDR_SOFT_RESET
		|=> soft_reset ##1 !soft_reset && audio_a == lighting_cfg_pkg::AUDIO_A_RESET)
		else $error("soft reset did not pulse or clear");
	a_limit_write: assert property (ce && wr_en && addr == lighting_cfg_pkg::ADDR_LIMIT1
		|=> limit1 == {2'h0, $past(wr_data[5:0])})
		else $error("first limit register write lost");
	a_limit_top_zero: assert property (limit1.zero == 2'h0 && limit2.zero == 2'h0)
		else $error("limit top bits not zero");
	a_audio_a_write: assert property (ce && wr_en && addr == lighting_cfg_pkg::ADDR_AUDIO_A
		|=> audio_a == $past(wr_data))
		else $error("audio control A write lost");
	a_adc_src_reset: assert property ($fell(sys_rst) |-> audio_a.adc_src == 2'h3 && audio_a.gain == 3'h0)
		else $error("audio control A reset value wrong");
	a_speed_write: assert property (ce && wr_en && addr == lighting_cfg_pkg::ADDR_AUDIO_B
		|=> audio_b.speed == $past(wr_data[1:0]) && audio_b.zero == 3'h0)
		else $error("speed field write wrong");
	a_fast_update: assert property (ce && !audio_b.avg_en && adc_done |=> adc_update)
		else $error("unaveraged sample did not update");
	a_start_run: assert property (ce && state_reg == lighting_cfg_pkg::SEQ_IDLE && pat_reg.start
		&& !start_prev_reg |=> seq_load && seq_step == 3'h0)
		else $error("start did not begin at first command");
	a_stop_clear: assert property (ce && !pat_reg.start |=> !seq_active)
		else $error("clearing start did not stop");
	a_wrap_repeat: assert property (ce && state_reg == lighting_cfg_pkg::SEQ_HOLD && exec_done
		&& idx_reg == 3'h7 && pat_reg.repeat_en && pat_reg.start |=> seq_load && seq_step == 3'h0)
		else $error("pattern did not wrap");

	c_soft_reset: cover property (disable iff (sys_rst) soft_reset);
	c_ramp_hold: cover property (state_reg == lighting_cfg_pkg::SEQ_RAMP ##1 state_reg == lighting_cfg_pkg::SEQ_HOLD);
	c_avg_update: cover property (audio_b.avg_en && adc_update);

endmodule

// ==== dv/host_model.sv ====
// Host model that reaches the register bank through byte write and read strobes
`timescale 1ns/1ps
module host_model (
	input wire logic sys_clk,
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data
);
	// ==================================================
	// Idle bus
	initial
	begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wr_data = 8'h00;
	end

	// ==================================================
	// Transfers, one strobe cycle each
	// Released lines show the inverse so a stale value never passes for a live one
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		wr_en = 1'b1;
		addr = a;
		wr_data = d;
		@(negedge sys_clk);
		wr_en = 1'b0;
		addr = ~a;
		wr_data = ~d;
	endtask

	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge sys_clk);
		rd_en = 1'b0;
		addr = ~a;
		d = rd_data;
	endtask
endmodule

// ==== dv/tb_lighting_cfg_regs.sv ====
// Self-checking testbench for the lighting configuration register bank
`timescale 1ns/1ps
module tb_lighting_cfg_regs;
	// ==================================================
	// Bench state
	// Short tick keeps eight-command patterns within the run budget
	localparam int TC = 2;
	localparam logic [6:0] LIN [8] = '{7'h00, 7'h07, 7'h0e, 7'h15, 7'h20, 7'h2e, 7'h47, 7'h64};
	localparam logic [6:0] LOG [8] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h0a, 7'h15, 7'h2e, 7'h64};
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic wr_en, rd_en, soft_reset, seq_active, adc_sample, adc_update;
	logic [7:0] addr, wr_data, rd_data, rv;
	logic [2:0] seq_step;
	lighting_cfg_pkg::limit_reg_t limit1, limit2;
	lighting_cfg_pkg::audio_a_t audio_a;
	lighting_cfg_pkg::audio_b_t audio_b;
	lighting_cfg_pkg::color_t colour;
	int bad_count = 0;
	int n_checks = 0;

	always #2.5 sys_clk = ~sys_clk;

	host_model u_host_model (.sys_clk(sys_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wr_data(wr_data), .rd_data(rd_data));

	lighting_cfg_regs #(.TICK_CYCLES(TC)) u_lighting_cfg_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.ce(ce), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
		.soft_reset(soft_reset), .limit1(limit1), .limit2(limit2), .audio_a(audio_a), .audio_b(audio_b),
		.colour(colour), .seq_active(seq_active), .seq_step(seq_step), .adc_sample(adc_sample),
		.adc_update(adc_update));

	// ==================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
		u_host_model.read(a, rv);
		check("rd_data", {24'h0, rv}, {24'h0, exp});
	endtask

	task automatic wait_step(input logic [2:0] s);
		int k;
		k = 0;
		while (!(seq_active === 1'b1 && seq_step === s) && k < 20000)
		begin
			@(negedge sys_clk);
			k++;
		end
		check("seq_step", {29'h0, seq_step}, {29'h0, s});
	endtask

	task automatic gap(output int k);
		k = 0;
		do
		begin
			@(negedge sys_clk);
			k++;
		end
		while (adc_sample !== 1'b1 && k < 400);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ==================================================
	// Scenarios
	task automatic t_reset_values;
		check("limit1", limit1, 32'h0);
		rd_check(8'h2a, 8'h03);
		rd_check(8'h2b, 8'h00);
	endtask

	task automatic t_limits;
		logic [1:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = 2'(i);
			u_host_model.write(8'h12, {2'b11, c, ~c, c});
			u_host_model.write(8'h13, {2'b10, ~c, c, ~c});
			check("limit1", limit1, {26'h0, c, ~c, c});
			check("limit2", limit2, {26'h0, ~c, c, ~c});
			rd_check(8'h13, {2'b00, ~c, c, ~c});
		end
	endtask

	task automatic t_audio;
		logic [7:0] v;
		for (int i = 0; i < 8; i++)
		begin
			v = {3'(i), i[0], i[1], i[2], 2'(i)};
			u_host_model.write(8'h2a, v);
			check("audio_a", audio_a, {24'h0, v});
			rd_check(8'h2a, v);
		end
		u_host_model.write(8'h2b, 8'hff);
		check("audio_b", audio_b, 32'h1f);
		rd_check(8'h2b, 8'h1f);
	endtask

	task automatic t_bus;
		rd_check(8'h60, 8'h00);
		rd_check(8'h70, 8'h00);
		u_host_model.write(8'h12, 8'h2a);
		ce = 1'b0;
		u_host_model.write(8'h12, 8'h15);
		ce = 1'b1;
		check("limit1 frozen", limit1, 32'h2a);
	endtask

	task automatic t_steps;
		for (int i = 0; i < 16; i++)
			u_host_model.write(8'h50 + 8'(i), 8'h5a ^ 8'(i * 17));
		for (int i = 0; i < 16; i++)
			rd_check(8'h50 + 8'(i), 8'h5a ^ 8'(i * 17));
	endtask

	task automatic t_adc;
		int k, n;
		u_host_model.write(8'h2b, 8'h00);
		gap(k);
		gap(k);
		check("sample gap", {31'h0, k >= 81 * TC && k <= 81 * TC + 2}, 32'h1);
		u_host_model.write(8'h2b, 8'h10);
		gap(k);
		gap(k);
		check("avg gap", {31'h0, k >= 40 * TC && k <= 40 * TC + 2}, 32'h1);
		k = 0;
		while (adc_update !== 1'b1 && k < 8000)
		begin
			@(negedge sys_clk);
			k++;
		end
		n = 0;
		k = 0;
		do
		begin
			@(negedge sys_clk);
			k++;
			n += int'(adc_sample === 1'b1);
		end
		while (adc_update !== 1'b1 && k < 8000);
		check("avg samples", n, 32'h40);
	endtask

	// Command 1 uses execution code 0001 so a swapped byte order shows up as a wrong length
	// Command 2 ramps with code 001, so an instant jump or an endless ramp shows up
	task automatic t_sequence(input logic log_on, input logic rpt);
		int k;
		logic [6:0] t [8];
		for (int n = 0; n < 8; n++)
		begin
			t[n] = log_on ? LOG[n] : LIN[n];
			u_host_model.write(8'h50 + 8'(2 * n), {3'(n), 3'(7 - n), 2'b00});
			u_host_model.write(8'h51 + 8'(2 * n), {(n == 0) ? 2'b01 : 2'b00, 3'(n), (n == 1) ? 3'b001 : 3'b000});
		end
		u_host_model.write(8'h11, {5'h00, 1'b1, rpt, log_on});
		for (int n = 0; n < 8; n++)
		begin
			wait_step(3'(n));
			repeat (20) @(negedge sys_clk);
			if (n == 1)
			begin
				check("ramp green", {31'h0, colour.green > t[6]}, 32'h1);
				repeat (55 * 10 * TC) @(negedge sys_clk);
			end
			check("colour", colour, {11'h0, t[n], t[7 - n], t[n]});
			k = 20;
			while (n == 0 && seq_step === 3'h0 && k < 9000)
			begin
				@(negedge sys_clk);
				k++;
			end
			if (n == 0)
				check("exec time", {31'h0, k > 393 * 10 * TC - 8 && k < 393 * 10 * TC + 8}, 32'h1);
		end
		k = 0;
		if (rpt)
		begin
			wait_step(3'h0);
			u_host_model.write(8'h11, 8'h00);
			@(negedge sys_clk);
		end
		else
			while (seq_active !== 1'b0 && k < 5000)
			begin
				@(negedge sys_clk);
				k++;
			end
		check("seq_active", {31'h0, seq_active}, 32'h0);
		@(negedge sys_clk);
		check("colour idle", colour, 32'h0);
		u_host_model.write(8'h11, 8'h00);
	endtask

	task automatic t_soft_reset;
		u_host_model.write(8'h2a, 8'hfc);
		u_host_model.write(8'h13, 8'h3f);
		u_host_model.write(8'h60, 8'h5a);
		check("soft_reset", {31'h0, soft_reset}, 32'h1);
		@(negedge sys_clk);
		check("soft_reset", {31'h0, soft_reset}, 32'h0);
		check("limit2", limit2, 32'h0);
		check("audio_a", audio_a, 32'h03);
		rd_check(8'h50, 8'h00);
	endtask

	// ==================================================
	// Main sequence and watchdog
	initial
	begin
		repeat (12) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset_values();
		t_limits();
		t_audio();
		t_bus();
		t_steps();
		t_adc();
		t_sequence(1'b0, 1'b0);
		t_sequence(1'b1, 1'b1);
		t_soft_reset();
		end_sim();
	end

	initial
	begin
		repeat (95000) @(posedge sys_clk);
		bad_count++;
		$display("wrong value watchdog expected done seen timeout");
		end_sim();
	end
endmodule
